//--- design/dss_top.sv
// Drive status word, bus speed reference and output frequency registers.
// Assumes condition flags and the frequency value come from drive logic
// on sys_clk; the fieldbus framing layer presents one register access
// at a time as a single-cycle strobe with a holding register number.
`timescale 1ns/100ps

// Overview of operation
// - Bit 0 set when control section ready, cleared on trip.
// - Bit 1 set when ready for operation, even with coast active.
// - Bit 2 clear while motor released by coast, else set.
// - Bit 3 set while tripped, cleared after reset restores operation.
// - Bit 4 set while an error without trip is present.
// - Bit 5 reserved, reads zero, carries no meaning.
// - Bit 6 set while tripped and locked.
// - Bit 7 set while any warning is active.
// - Bit 8 set when motor speed equals the speed reference.
// - Bit 9 set when bus control is permitted, clear when local forced.
// - Bit 10 set while output frequency is inside its limits.
// - Bit 11 set when start is present without coast.
// - Bit 12 set during temporary overtemperature stop, clears itself.
// - Bit 13 set when DC link voltage is too low or too high.
// - Bit 14 set while motor current exceeds the current limit.
// - Bit 15 set when either thermal timer exceeds full scale.
// - Speed reference is 16-bit relative; 16384 means full range.
// - Negative speed references are two's complement.
// - Output frequency uses the same signed relative scaling.
// - Status and frequency at 50200/50210, mirrored at 02910/02911.
module dss_top
    import dss_pkg::*;
(
    input  wire logic        sys_clk,         // 100 MHz system clock
    input  wire logic        sys_rst,         // Synchronous reset, high
    // Register access from the fieldbus framing layer
    input  wire logic        bus_rd,          // Read strobe, one cycle
    input  wire logic        bus_wr,          // Write strobe, one cycle
    input  wire logic [15:0] bus_addr,        // Holding register number
    input  wire logic [15:0] bus_wdata,       // Write data
    output logic      [15:0] bus_rdata,       // Read data, registered
    output logic             bus_ack,         // Access done, one cycle
    output logic             bus_err,         // Unmapped or read-only
    // Drive condition flags, sys_clk domain
    input  wire logic        ctrl_ready,      // Control section ready
    input  wire logic        tripped,         // Tripped fault state
    input  wire logic        trip_locked,     // Tripped and locked
    input  wire logic        drive_ready,     // Ready for operation
    input  wire logic        coast_active,    // Coast command active
    input  wire logic        error_no_trip,   // Error without trip
    input  wire logic        warning,         // Any warning active
    input  wire logic        at_speed,        // Speed equals reference
    input  wire logic        local_forced,    // Local operation forced
    input  wire logic        freq_at_limit,   // Frequency at a limit
    input  wire logic        start_present,   // Start signal present
    input  wire logic        overtemp_hold,   // Overtemperature stop
    input  wire logic        dc_volt_fault,   // DC link out of range
    input  wire logic        current_limit,   // Current over limit
    input  wire logic        motor_timer,     // Motor thermal over
    input  wire logic        drive_timer,     // Drive thermal over
    input  wire logic [15:0] output_freq,     // Signed relative freq
    // Drive-facing outputs
    output logic      [15:0] speed_reference, // Signed relative ref
    output logic      [15:0] control_word,    // Last control word
    output logic             control_strobe,  // New control word
    output logic      [15:0] status_word      // Current status word
);

    // Decoded register target
    typedef enum logic [2:0] {
        DSS_TGT_NONE,
        DSS_TGT_CTRL,
        DSS_TGT_REF,
        DSS_TGT_STAT,
        DSS_TGT_FREQ
    } dss_tgt_t;

    // All module state
    typedef struct packed {
        logic [15:0] ref_val;
        logic [15:0] ctrl_val;
        logic        ctrl_pulse;
        logic [15:0] status;
        logic [15:0] freq;
        logic [15:0] rdata;
        logic        ack;
        logic        err;
    } dss_state_t;

    dss_state_t  cur;
    dss_state_t  next_cur;
    dss_tgt_t    tgt;
    dss_acc_t    acc;
    logic [15:0] built_word;

    dss_cond_if cond ();

    // Main and mirrored areas decode alike
    function automatic dss_tgt_t dss_decode(input logic [15:0] addr);
        dss_tgt_t t;
        t = DSS_TGT_NONE;
        case (addr)
            DSS_REG_CTRL_MAIN, DSS_REG_CTRL_LOW: t = DSS_TGT_CTRL;
            DSS_REG_REF_MAIN,  DSS_REG_REF_LOW:  t = DSS_TGT_REF;
            DSS_REG_STAT_MAIN, DSS_REG_STAT_LOW: t = DSS_TGT_STAT;
            DSS_REG_FREQ_MAIN, DSS_REG_FREQ_LOW: t = DSS_TGT_FREQ;
            default:                             t = DSS_TGT_NONE;
        endcase
        return t;
    endfunction

    // Flags into the builder
    assign cond.ctrl_ready    = ctrl_ready;
    assign cond.tripped       = tripped;
    assign cond.trip_locked   = trip_locked;
    assign cond.drive_ready   = drive_ready;
    assign cond.coast_active  = coast_active;
    assign cond.error_no_trip = error_no_trip;
    assign cond.warning       = warning;
    assign cond.at_speed      = at_speed;
    assign cond.local_forced  = local_forced;
    assign cond.freq_at_limit = freq_at_limit;
    assign cond.start_present = start_present;
    assign cond.overtemp_hold = overtemp_hold;
    assign cond.dc_volt_fault = dc_volt_fault;
    assign cond.current_limit = current_limit;
    assign cond.motor_timer   = motor_timer;
    assign cond.drive_timer   = drive_timer;
    assign built_word         = cond.status_word;

    dss_status_build u_build (
        .cond (cond.bld)
    );

    assign tgt = dss_decode(bus_addr);

    // Access classification; status and frequency refuse writes
    always_comb begin
        acc = DSS_ACC_NONE;
        if (bus_rd || bus_wr) begin
            if (tgt == DSS_TGT_NONE) begin
                acc = DSS_ACC_BAD_ADDR;
            end else if (bus_wr && (tgt == DSS_TGT_STAT
                                    || tgt == DSS_TGT_FREQ)) begin
                acc = DSS_ACC_READ_ONLY;
            end else begin
                acc = DSS_ACC_OK;
            end
        end
    end

    // Next-state logic
    always_comb begin
        next_cur            = cur;
        next_cur.ctrl_pulse = 1'b0;
        next_cur.ack        = 1'b0;
        next_cur.err        = 1'b0;
        // Snapshot taken every cycle so all bits belong together
        next_cur.status     = built_word;
        // Frequency passed through unchanged, same scaling as ref
        next_cur.freq       = output_freq;
        if (acc != DSS_ACC_NONE) begin
            next_cur.ack = 1'b1;
            next_cur.err = (acc != DSS_ACC_OK);
        end
        // A write wins over a read in the same cycle; a write to both at once is impossible
        if (acc == DSS_ACC_OK && bus_wr) begin
            case (tgt)
                DSS_TGT_CTRL: begin
                    next_cur.ctrl_val   = bus_wdata;
                    next_cur.ctrl_pulse = 1'b1;
                end
                // Stored as raw two's complement, no clamping
                DSS_TGT_REF:  next_cur.ref_val = bus_wdata;
                default:      next_cur.ref_val = cur.ref_val;
            endcase
        end
        // Reads return the registered snapshot, not the live flags
        if (acc == DSS_ACC_OK && bus_rd && !bus_wr) begin
            case (tgt)
                DSS_TGT_CTRL: next_cur.rdata = cur.ctrl_val;
                DSS_TGT_REF:  next_cur.rdata = cur.ref_val;
                DSS_TGT_STAT: next_cur.rdata = cur.status;
                DSS_TGT_FREQ: next_cur.rdata = cur.freq;
                default:      next_cur.rdata = DSS_RST_STATUS;
            endcase
        end else if (acc != DSS_ACC_NONE) begin
            next_cur.rdata = DSS_RST_STATUS;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur.ref_val    <= DSS_RST_REF;
            cur.ctrl_val   <= DSS_RST_CTRL;
            cur.ctrl_pulse <= 1'b0;
            cur.status     <= DSS_RST_STATUS;
            cur.freq       <= DSS_RST_FREQ;
            cur.rdata      <= DSS_RST_STATUS;
            cur.ack        <= 1'b0;
            cur.err        <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from state
    assign bus_rdata       = cur.rdata;
    assign bus_ack         = cur.ack;
    assign bus_err         = cur.err;
    assign speed_reference = cur.ref_val;
    assign control_word    = cur.ctrl_val;
    assign control_strobe  = cur.ctrl_pulse;
    assign status_word     = cur.status;

endmodule // dss_top

//--- design/dss_pkg.sv
// Package for the drive status word and speed reference register bank.
// Assumes a single 100 MHz clock domain; imported by dss_top and dss_status_build.
package dss_pkg;

    // Holding register numbers, main area and mirrored lower area
    localparam logic [15:0] DSS_REG_CTRL_MAIN   = 16'hc350; // 50000
    localparam logic [15:0] DSS_REG_REF_MAIN    = 16'hc35a; // 50010
    localparam logic [15:0] DSS_REG_STAT_MAIN   = 16'hc418; // 50200
    localparam logic [15:0] DSS_REG_FREQ_MAIN   = 16'hc422; // 50210
    localparam logic [15:0] DSS_REG_CTRL_LOW    = 16'h0afa; // 02810
    localparam logic [15:0] DSS_REG_REF_LOW     = 16'h0afb; // 02811
    localparam logic [15:0] DSS_REG_STAT_LOW    = 16'h0b5e; // 02910
    localparam logic [15:0] DSS_REG_FREQ_LOW    = 16'h0b5f; // 02911

    // Status word bit positions
    localparam int DSS_BIT_CTRL_READY   = 0;
    localparam int DSS_BIT_DRIVE_READY  = 1;
    localparam int DSS_BIT_ENABLE       = 2;
    localparam int DSS_BIT_TRIP         = 3;
    localparam int DSS_BIT_ERROR        = 4;
    localparam int DSS_BIT_RESERVED     = 5;
    localparam int DSS_BIT_TRIPLOCK     = 6;
    localparam int DSS_BIT_WARNING      = 7;
    localparam int DSS_BIT_AT_SPEED     = 8;
    localparam int DSS_BIT_BUS_CONTROL  = 9;
    localparam int DSS_BIT_FREQ_OK      = 10;
    localparam int DSS_BIT_IN_OPERATION = 11;
    localparam int DSS_BIT_AUTO_START   = 12;
    localparam int DSS_BIT_VOLTAGE      = 13;
    localparam int DSS_BIT_TORQUE       = 14;
    localparam int DSS_BIT_TIMER        = 15;

    // Relative scaling: 16384 is full reference range
    localparam logic [15:0] DSS_REF_FULL_SCALE  = 16'h4000;

    // Reset values
    localparam logic [15:0] DSS_RST_REF         = 16'h0000;
    localparam logic [15:0] DSS_RST_CTRL        = 16'h0000;
    localparam logic [15:0] DSS_RST_STATUS      = 16'h0000;
    localparam logic [15:0] DSS_RST_FREQ        = 16'h0000;

    // Bus access result
    typedef enum logic [1:0] {
        DSS_ACC_NONE,
        DSS_ACC_OK,
        DSS_ACC_BAD_ADDR,
        DSS_ACC_READ_ONLY
    } dss_acc_t;

endpackage : dss_pkg

//--- design/dss_cond_if.sv
// Interface carrying the drive condition flags between the top module
// and the status-word builder. Same clock domain on both sides.
`timescale 1ns/100ps
interface dss_cond_if;
    logic        ctrl_ready;    // Control section ready
    logic        tripped;       // Tripped fault state
    logic        trip_locked;   // Tripped and locked
    logic        drive_ready;   // Ready for operation
    logic        coast_active;  // Coast command active
    logic        error_no_trip; // Error without trip
    logic        warning;       // Any warning
    logic        at_speed;      // Speed equals reference
    logic        local_forced;  // Local operation forced
    logic        freq_at_limit; // Output frequency at a limit
    logic        start_present; // Start signal present
    logic        overtemp_hold; // Temporary overtemperature stop
    logic        dc_volt_fault; // DC link too low or too high
    logic        current_limit; // Current above limit
    logic        motor_timer;   // Motor thermal timer over full scale
    logic        drive_timer;   // Drive thermal timer over full scale
    logic [15:0] status_word;   // Assembled status word

    modport src (output ctrl_ready, tripped, trip_locked, drive_ready,
                 coast_active, error_no_trip, warning, at_speed,
                 local_forced, freq_at_limit, start_present,
                 overtemp_hold, dc_volt_fault, current_limit,
                 motor_timer, drive_timer, input status_word);
    modport bld (input ctrl_ready, tripped, trip_locked, drive_ready,
                 coast_active, error_no_trip, warning, at_speed,
                 local_forced, freq_at_limit, start_present,
                 overtemp_hold, dc_volt_fault, current_limit,
                 motor_timer, drive_timer, output status_word);
endinterface : dss_cond_if

//--- design/dss_status_build.sv
// Combinational assembly of the sixteen-bit drive status word.
// Assumes its condition flags are already in the system clock domain.
`timescale 1ns/100ps
module dss_status_build
    import dss_pkg::*;
(
    dss_cond_if.bld cond    // Condition flags in, word out
);

    logic [15:0] word;

    // Each bit mapped from its condition
    always_comb begin
        word = DSS_RST_STATUS;
        // A trip overrides control ready
        word[DSS_BIT_CTRL_READY]   = cond.ctrl_ready & ~cond.tripped;
        word[DSS_BIT_DRIVE_READY]  = cond.drive_ready;
        word[DSS_BIT_ENABLE]       = ~cond.coast_active;
        word[DSS_BIT_TRIP]         = cond.tripped;
        word[DSS_BIT_ERROR]        = cond.error_no_trip;
        word[DSS_BIT_RESERVED]     = 1'b0;
        word[DSS_BIT_TRIPLOCK]     = cond.trip_locked;
        word[DSS_BIT_WARNING]      = cond.warning;
        word[DSS_BIT_AT_SPEED]     = cond.at_speed;
        word[DSS_BIT_BUS_CONTROL]  = ~cond.local_forced;
        word[DSS_BIT_FREQ_OK]      = ~cond.freq_at_limit;
        word[DSS_BIT_IN_OPERATION] = cond.start_present
                                     & ~cond.coast_active;
        word[DSS_BIT_AUTO_START]   = cond.overtemp_hold;
        word[DSS_BIT_VOLTAGE]      = cond.dc_volt_fault;
        word[DSS_BIT_TORQUE]       = cond.current_limit;
        word[DSS_BIT_TIMER]        = cond.motor_timer
                                     | cond.drive_timer;
    end

    assign cond.status_word = word;

endmodule // dss_status_build

//--- test/dss_properties.sv
// Checker for the status word and register bank, bound to dss_top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module dss_properties
    import dss_pkg::*;
(
    input wire logic        sys_clk,         // System clock
    input wire logic        sys_rst,         // Synchronous reset
    input wire logic        bus_rd,          // Read strobe
    input wire logic        bus_wr,          // Write strobe
    input wire logic [15:0] bus_addr,        // Register number
    input wire logic [15:0] bus_wdata,       // Write data
    input wire logic [15:0] bus_rdata,       // Read data
    input wire logic        bus_ack,         // Access done
    input wire logic        bus_err,         // Access refused
    input wire logic        tripped,         // Trip flag
    input wire logic        coast_active,    // Coast flag
    input wire logic        motor_timer,     // Motor thermal flag
    input wire logic        drive_timer,     // Drive thermal flag
    input wire logic [15:0] speed_reference, // Reference out
    input wire logic [15:0] status_word      // Status out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic is_ref, is_ro, is_stat, mapped;
    // Address classes, mirrors included
    assign is_ref  = bus_addr == DSS_REG_REF_MAIN
                  || bus_addr == DSS_REG_REF_LOW;
    assign is_stat = bus_addr == DSS_REG_STAT_MAIN
                  || bus_addr == DSS_REG_STAT_LOW;
    assign is_ro   = is_stat || bus_addr == DSS_REG_FREQ_MAIN
                  || bus_addr == DSS_REG_FREQ_LOW;
    assign mapped  = is_ref || is_ro || bus_addr == DSS_REG_CTRL_MAIN
                  || bus_addr == DSS_REG_CTRL_LOW;

    property p_ack; (bus_rd || bus_wr) |=> bus_ack; endproperty
    property p_no_ack; !(bus_rd || bus_wr) |=> !bus_ack; endproperty
    property p_ref_wr;
        bus_wr && is_ref |=> speed_reference == $past(bus_wdata) && !bus_err;
    endproperty
    property p_ro_wr;
        bus_wr && is_ro |=> bus_err && $stable(speed_reference);
    endproperty
    property p_stat_rd;
        bus_rd && is_stat |=> bus_rdata == $past(status_word) && !bus_err;
    endproperty
    property p_unmapped;
        (bus_rd || bus_wr) && !mapped |=> bus_err && bus_rdata == 16'h0000;
    endproperty
    // Reset edges excluded: the register clears while flags stay set
    property p_trip;
        !sys_rst && tripped |=> status_word[3] && !status_word[0];
    endproperty
    property p_coast;
        !sys_rst && coast_active |=> !status_word[2] && !status_word[11];
    endproperty
    property p_timer;
        !sys_rst |=> status_word[15] == $past(motor_timer || drive_timer);
    endproperty
    property p_reserved; !status_word[5]; endproperty

    a_ack:      assert property (p_ack)
        else $error("no ack after strobe");
    a_no_ack:   assert property (p_no_ack)
        else $error("ack without strobe");
    a_ref_wr:   assert property (p_ref_wr)
        else $error("reference not taken");
    a_ro_wr:    assert property (p_ro_wr)
        else $error("read-only write taken");
    a_stat_rd:  assert property (p_stat_rd)
        else $error("status read wrong");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped not refused");
    a_trip:     assert property (p_trip)
        else $error("trip bits wrong");
    a_coast:    assert property (p_coast)
        else $error("coast bits wrong");
    a_timer:    assert property (p_timer)
        else $error("timer bit wrong");
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    // Main scenarios reached
    c_stat_rd: cover property (p_stat_rd);
    c_ref_wr:  cover property (bus_wr && is_ref);
    c_refused: cover property (bus_err);
endmodule // dss_properties

//--- test/dss_bus_master.sv
// Model of the fieldbus master behind the framing layer.
// Assumes one access at a time; strobe one cycle, ack one cycle later.
`timescale 1ns/100ps
module dss_bus_master (
    input  wire logic        sys_clk,   // System clock
    output logic             bus_rd,    // Read strobe
    output logic             bus_wr,    // Write strobe
    output logic      [15:0] bus_addr,  // Register number
    output logic      [15:0] bus_wdata, // Write data
    input  wire logic [15:0] bus_rdata, // Read data
    input  wire logic        bus_ack,   // Access done
    input  wire logic        bus_err    // Access refused
);
    // Idle bus at time zero
    initial begin
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
    end

    // One access; address held until ack seen, then scrambled so a
    // stale value is never mistaken for a held one
    task automatic access(input logic wr, input logic [15:0] addr,
                          input logic [15:0] wdata,
                          output logic [15:0] rdata, output logic err);
        int n;
        @(posedge sys_clk);
        bus_rd <= ~wr;
        bus_wr <= wr;
        bus_addr <= addr;
        bus_wdata <= wdata;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
        #1;
        n = 0;
        while (bus_ack !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        rdata = bus_rdata;
        err = bus_err | (bus_ack !== 1'b1);
        @(posedge sys_clk);
        bus_addr <= ~addr;
        bus_wdata <= ~wdata;
    endtask
endmodule // dss_bus_master

//--- test/dss_top_tb.sv
// Self-checking bench for dss_top: status bits, reference, frequency.
// Assumes dss_bus_master as the fieldbus side; 100 MHz sys_clk.
`timescale 1ns/100ps
module drive_status_and_speed_reference_tb;
    import dss_pkg::*;
    logic        sys_clk, sys_rst, bus_rd, bus_wr, bus_ack, bus_err, err_v;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, output_freq, fl, rd_v;
    logic [15:0] speed_reference, control_word, status_word;
    logic        control_strobe;
    int          num_errors = 0, checked = 0, cyc = 0, strobes = 0;

    // Free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    dss_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
        .ctrl_ready(fl[0]), .tripped(fl[1]), .trip_locked(fl[2]),
        .drive_ready(fl[3]), .coast_active(fl[4]), .error_no_trip(fl[5]),
        .warning(fl[6]), .at_speed(fl[7]), .local_forced(fl[8]),
        .freq_at_limit(fl[9]), .start_present(fl[10]),
        .overtemp_hold(fl[11]), .dc_volt_fault(fl[12]),
        .current_limit(fl[13]), .motor_timer(fl[14]), .drive_timer(fl[15]),
        .output_freq(output_freq), .speed_reference(speed_reference),
        .control_word(control_word), .control_strobe(control_strobe),
        .status_word(status_word));

    dss_bus_master m (.sys_clk(sys_clk), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .bus_err(bus_err));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Errors %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Status word from the flag vector, bit 15 down to bit 0
    function automatic logic [15:0] exp_stat(input logic [15:0] f);
        return {f[14] | f[15], f[13], f[12], f[11], f[10] & ~f[4], ~f[9],
                ~f[8], f[7], f[6], f[2], 1'b0, f[5], f[1], ~f[4], f[3],
                f[0] & ~f[1]};
    endfunction

    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    // Cycles of control strobe; each accepted control write gives one
    always @(posedge sys_clk) begin
        if (control_strobe === 1'b1) strobes <= strobes + 1;
    end

    // Main sequence
    initial begin
        logic [15:0] p;
        static logic [15:0] refs [4] = '{16'h4000, 16'hc000, 16'h7fff,
                                         16'h8000};
        static logic [15:0] bad [3] = '{DSS_REG_STAT_MAIN, DSS_REG_FREQ_LOW,
                                        16'h0001};
        sys_rst = 1'b1;
        fl = 16'h0000;
        output_freq = 16'h0000;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        m.access(1'b0, DSS_REG_REF_MAIN, 16'h0000, rd_v, err_v);
        check(rd_v, DSS_RST_REF);
        // Walking one through every flag, then none and all
        for (int j = 0; j < 18; j++) begin
            p = (j < 16) ? 16'h0001 << j : {16{j[0]}};
            @(posedge sys_clk);
            fl <= p;
            repeat (2) @(posedge sys_clk);
            #1;
            check(status_word, exp_stat(p));
            m.access(1'b0, DSS_REG_STAT_MAIN, 16'h0000, rd_v, err_v);
            check(rd_v, exp_stat(p));
            m.access(1'b0, DSS_REG_STAT_LOW, 16'h0000, rd_v, err_v);
            check(rd_v, exp_stat(p));
            check({15'h0000, err_v}, 16'h0000);
        end
        // Full scale, negative and extreme references; mirrored frequency
        foreach (refs[k]) begin
            // Write through one area, read back through the other
            m.access(1'b1, k[0] ? DSS_REG_REF_LOW : DSS_REG_REF_MAIN,
                     refs[k], rd_v, err_v);
            check(speed_reference, refs[k]);
            m.access(1'b0, k[0] ? DSS_REG_REF_MAIN : DSS_REG_REF_LOW,
                     16'h0000, rd_v, err_v);
            check(rd_v, refs[k]);
            @(posedge sys_clk);
            output_freq <= refs[k];
            m.access(1'b0, k[0] ? DSS_REG_FREQ_LOW : DSS_REG_FREQ_MAIN,
                     16'h0000, rd_v, err_v);
            check(rd_v, refs[k]);
        end
        m.access(1'b1, DSS_REG_CTRL_LOW, 16'h047f, rd_v, err_v);
        check(control_word, 16'h047f);
        m.access(1'b0, DSS_REG_CTRL_MAIN, 16'h0000, rd_v, err_v);
        check(rd_v, 16'h047f);
        // Refused writes leave state alone; each one reports an error
        foreach (bad[k]) begin
            m.access(1'b1, bad[k], 16'h1234, rd_v, err_v);
            check({15'h0000, err_v}, 16'h0001);
            check(speed_reference, 16'h8000);
        end
        // One control write, none from the refused writes
        check(strobes[15:0], 16'h0001);
        // Mid-run reset clears stored registers and the status word
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        check(speed_reference, DSS_RST_REF);
        check(control_word, DSS_RST_CTRL);
        check(status_word, DSS_RST_STATUS);
        m.access(1'b0, 16'h0001, 16'h0000, rd_v, err_v);
        check(rd_v, 16'h0000);
        check({15'h0000, err_v}, 16'h0001);
        #1;
        check(status_word, exp_stat(fl));
        print_verdict();
    end
endmodule // drive_status_and_speed_reference_tb

bind dss_top dss_properties u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .bus_err(bus_err), .tripped(tripped), .coast_active(coast_active),
    .motor_timer(motor_timer), .drive_timer(drive_timer),
    .speed_reference(speed_reference), .status_word(status_word));
